// [verilog/adcs_pkg.sv]
// Package: register map, field layout, timing and types of the sequencer
package adcs_pkg;

    // ***********************************************************
    // Register offsets
    // ***********************************************************
    localparam logic [7:0] CTRL_A_OFS   = 8'h00;
    localparam logic [7:0] INSEL_OFS    = 8'h04;
    localparam logic [7:0] CTRL_B_OFS   = 8'h08;
    localparam logic [7:0] RES_LOW_OFS  = 8'h0C;
    localparam logic [7:0] RES_HIGH_OFS = 8'h10;
    localparam logic [7:0] POWER_OFS    = 8'h14;

    // ***********************************************************
    // Field positions
    // ***********************************************************
    localparam int CA_ENABLE = 7;
    localparam int CA_START  = 6;
    localparam int CA_AUTO   = 5;
    localparam int CA_FLAG   = 4;
    localparam int IS_LEFT   = 5;
    localparam int IS_REF    = 6;

    // ***********************************************************
    // Reset values
    // ***********************************************************
    localparam logic [2:0] PRESCALE_RST = 3'h0;
    localparam logic [3:0] CHANNEL_RST  = 4'h0;
    localparam logic [1:0] REF_RST      = 2'h0;
    localparam logic [2:0] TRIGSEL_RST  = 3'h0;
    localparam logic       POWER_RST    = 1'b0;

    // ***********************************************************
    // Channel codes and trigger codes
    // ***********************************************************
    localparam logic [3:0] CH_BANDGAP = 4'hE;
    localparam logic [3:0] CH_GROUND  = 4'hF;
    localparam logic [2:0] TRIG_FREE  = 3'h0;

    // ***********************************************************
    // Timing, in half converter clock cycles; sync depth in system clocks
    // ***********************************************************
    localparam logic [5:0] NORMAL_SH   = 6'h03;
    localparam logic [5:0] NORMAL_DONE = 6'h1A;
    localparam logic [5:0] FIRST_SH    = 6'h1B;
    localparam logic [5:0] FIRST_DONE  = 6'h32;
    localparam logic [5:0] AUTO_SH     = 6'h04;
    localparam logic [5:0] AUTO_DONE   = 6'h1B;
    localparam int         SYNC_CYCLES = 3;

    // ***********************************************************
    // Types
    // ***********************************************************
    typedef enum logic [1:0] {IDLE, WAIT_EDGE, CONVERT} adcs_state_t;

    typedef struct packed {
        logic       enable;
        logic       convert;
        logic       sampleHold;
        logic       firstConv;
        logic [3:0] channel;
        logic [1:0] reference;
    } adcs_analog_t;

endpackage

// [verilog/adcs_prescaler.sv]
// Prescaler: converter clock edges as enable pulses from the system clock
`timescale 1ns/1ps
module adcs_prescaler (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       nrst,
    // Control
    input  wire logic       run,
    input  wire logic       restart,
    input  wire logic [2:0] sel,
    // Converter clock edges
    output logic            riseTick,
    output logic            fallTick
);
    logic [7:0] count;
    logic [7:0] divisor;

    // Codes 0 and 1 both divide by two
    assign divisor  = (sel == 3'h0) ? 8'h02 : 8'(8'h01 << sel);
    assign riseTick = run && !restart && (count == divisor - 8'h01);
    assign fallTick = run && !restart && (count == (divisor >> 1) - 8'h01);

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            count <= 8'h00;
        end else if (!run || restart || riseTick) begin
            count <= 8'h00;
        end else begin
            count <= count + 8'h01;
        end
    end
endmodule

// [verilog/adcs_sequencer.sv]
// Conversion sequencer: APB registers, start logic, timing and results
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
// Operation
// - Ten-bit code, zero at ground, all ones at reference less one step
// - Channel field picks eight pins, ground or bandgap
// - With enable clear, selections inert and converter fully idle
// - Result right-justified by default, left-justified when select bit set
// - Low byte read locks both bytes until high byte read
// - Complete flag still sets when a locked result is discarded
// - Start bit begins one conversion, reads one while busy, self-clears
// - Channel change mid-conversion waits for that conversion to end
// - Auto-trigger rising edge resets prescaler and starts conversion
// - Edges during conversion ignored; held-high trigger never restarts
// - Complete-flag trigger gives back-to-back conversions regardless of flag
// - Start bit works with auto-trigger and reads one whenever busy
// - Prescaler counts from enable, held reset while disabled
// - Start bit conversion begins at next converter clock rising edge
// - Ordinary conversion 13 cycles, first after enable 25 cycles
// - Sample-and-hold at 1.5 cycles, or 13.5 on first conversion
// - Completion writes result, sets flag, clears start bit in single mode
// - Auto conversion: hold two cycles after edge, 13.5 total, 3 sync clocks
// - Free running restarts at once, start bit stays set
// - Power-reduction bit one disables the converter
// - Selection buffer frozen from start until last cycle before completion
module adcs_sequencer #(
    parameter int TRIG_LINES = 8
) (
    // Clock and reset
    input  wire logic                    clock,
    input  wire logic                    nrst,
    // APB slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [7:0]              paddr,
    input  wire logic [31:0]             pwdata,
    output logic                         pready,
    output logic                         pslverr,
    output logic [31:0]                  prdata,
    // Trigger event lines, line 0 unused
    input  wire logic [TRIG_LINES-1:0]   trigLines,
    // Analog converter
    input  wire logic [9:0]              convCode,
    output adcs_pkg::adcs_analog_t       analog
);
    // ***********************************************************
    // Registers and state
    // ***********************************************************
    logic                  enable;
    logic                  startReq;
    logic                  autoTrig;
    logic                  flag;
    logic [2:0]            prescale;
    logic [3:0]            channel;
    logic [1:0]            reference;
    logic                  leftJustify;
    logic [2:0]            trigSelect;
    logic                  powerReduce;
    logic [9:0]            result;
    logic                  locked;
    logic [3:0]            bufChannel;
    logic [1:0]            bufReference;
    adcs_pkg::adcs_state_t state;
    logic [5:0]            halfCount;
    logic [5:0]            shHalf;
    logic [5:0]            doneHalf;
    logic                  firstPending;
    logic                  trigPrev;
    logic [adcs_pkg::SYNC_CYCLES-1:0] syncPipe;

    logic       effEnable;
    logic       wrAccess;
    logic       rdAccess;
    logic       riseTick;
    logic       fallTick;
    logic       halfTick;
    logic       done;
    logic       freeRun;
    logic       trigLevel;
    logic       trigEdge;
    logic       autoStart;
    logic       startWrite;
    logic       unfrozen;
    logic       flagClear;
    logic [7:0] resLowView;
    logic [7:0] resHighView;
    logic [7:0] ctrlAView;

    // ***********************************************************
    // Bus decode
    // ***********************************************************
    assign pready   = 1'b1;
    assign wrAccess = psel && penable && pwrite;
    assign rdAccess = psel && penable && !pwrite;

    assign effEnable = enable && !powerReduce;
    assign halfTick  = riseTick || fallTick;
    assign freeRun   = autoTrig && (trigSelect == adcs_pkg::TRIG_FREE);
    assign done      = (state == adcs_pkg::CONVERT) && halfTick
                       && (halfCount + 6'h01 == doneHalf);
    assign unfrozen  = (state != adcs_pkg::CONVERT)
                       || (halfCount + 6'h02 >= doneHalf);
    assign startWrite = wrAccess && (paddr == adcs_pkg::CTRL_A_OFS)
                        && pwdata[adcs_pkg::CA_START];
    assign flagClear  = wrAccess && (paddr == adcs_pkg::CTRL_A_OFS)
                        && pwdata[adcs_pkg::CA_FLAG];

    // ***********************************************************
    // Auto trigger
    // ***********************************************************
    assign trigLevel = trigLines[trigSelect];
    // Edge only, so a level still high at completion starts nothing
    assign trigEdge  = trigLevel && !trigPrev;
    assign autoStart = syncPipe[adcs_pkg::SYNC_CYCLES-1]
                       && (state != adcs_pkg::CONVERT);

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            trigPrev <= 1'b0;
        end else begin
            trigPrev <= trigLevel;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            syncPipe <= '0;
        end else if (!effEnable || !autoTrig || freeRun) begin
            syncPipe <= '0;
        end else begin
            // Edges during a conversion are dropped here
            syncPipe <= {syncPipe[adcs_pkg::SYNC_CYCLES-2:0],
                         trigEdge && (state != adcs_pkg::CONVERT)};
        end
    end

    adcs_prescaler u_prescaler (
        .clock    (clock),
        .nrst     (nrst),
        .run      (effEnable),
        .restart  (autoStart),
        .sel      (prescale),
        .riseTick (riseTick),
        .fallTick (fallTick)
    );

    // ***********************************************************
    // Conversion sequence
    // ***********************************************************
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state <= adcs_pkg::IDLE;
        end else if (!effEnable) begin
            state <= adcs_pkg::IDLE;
        end else begin
            unique case (state)
                adcs_pkg::IDLE: begin
                    if (autoStart) begin
                        state <= adcs_pkg::CONVERT;
                    end else if (startWrite) begin
                        state <= adcs_pkg::WAIT_EDGE;
                    end
                end
                adcs_pkg::WAIT_EDGE: begin
                    if (autoStart) begin
                        state <= adcs_pkg::CONVERT;
                    end else if (riseTick) begin
                        state <= adcs_pkg::CONVERT;
                    end
                end
                adcs_pkg::CONVERT: begin
                    // A start written in the completion cycle is kept
                    if (done && !freeRun && startWrite) begin
                        state <= adcs_pkg::WAIT_EDGE;
                    end else if (done && !freeRun) begin
                        state <= adcs_pkg::IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            halfCount <= 6'h00;
            shHalf    <= adcs_pkg::NORMAL_SH;
            doneHalf  <= adcs_pkg::NORMAL_DONE;
        end else if (autoStart && state != adcs_pkg::CONVERT) begin
            halfCount <= 6'h00;
            shHalf    <= firstPending ? adcs_pkg::FIRST_SH
                                      : adcs_pkg::AUTO_SH;
            doneHalf  <= firstPending ? adcs_pkg::FIRST_DONE
                                      : adcs_pkg::AUTO_DONE;
        end else if ((state == adcs_pkg::WAIT_EDGE && riseTick)
                     || (done && freeRun)) begin
            halfCount <= 6'h00;
            shHalf    <= firstPending ? adcs_pkg::FIRST_SH
                                      : adcs_pkg::NORMAL_SH;
            doneHalf  <= firstPending ? adcs_pkg::FIRST_DONE
                                      : adcs_pkg::NORMAL_DONE;
        end else if (state == adcs_pkg::CONVERT && halfTick) begin
            halfCount <= halfCount + 6'h01;
        end
    end

    // First conversion after enable gets the long initialisation
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            firstPending <= 1'b1;
        end else if (!effEnable) begin
            firstPending <= 1'b1;
        end else if (state == adcs_pkg::CONVERT) begin
            firstPending <= 1'b0;
        end
    end

    // ***********************************************************
    // Selection buffer and analog outputs
    // ***********************************************************
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            bufChannel   <= adcs_pkg::CHANNEL_RST;
            bufReference <= adcs_pkg::REF_RST;
        end else if (unfrozen) begin
            bufChannel   <= channel;
            bufReference <= reference;
        end
    end

    always_comb begin
        analog            = '0;
        analog.enable     = effEnable;
        analog.convert    = (state == adcs_pkg::CONVERT);
        analog.sampleHold = analog.convert && (halfCount == shHalf);
        analog.firstConv  = analog.convert && (shHalf == adcs_pkg::FIRST_SH);
        analog.reference  = effEnable ? bufReference : adcs_pkg::REF_RST;
        // Reserved codes fall back to ground
        if (!effEnable) begin
            analog.channel = adcs_pkg::CH_GROUND;
        end else if (bufChannel[3] && bufChannel != adcs_pkg::CH_BANDGAP) begin
            analog.channel = adcs_pkg::CH_GROUND;
        end else begin
            analog.channel = bufChannel;
        end
    end

    // ***********************************************************
    // Result and flag
    // ***********************************************************
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            result <= 10'h000;
        end else if (done && !locked) begin
            result <= convCode;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            locked <= 1'b0;
        end else if (rdAccess && paddr == adcs_pkg::RES_HIGH_OFS) begin
            locked <= 1'b0;
        end else if (rdAccess && paddr == adcs_pkg::RES_LOW_OFS) begin
            locked <= 1'b1;
        end
    end

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            flag <= 1'b0;
        end else if (done) begin
            flag <= 1'b1;
        end else if (flagClear) begin
            flag <= 1'b0;
        end
    end

    assign resLowView  = leftJustify ? {result[1:0], 6'h00}
                                     : result[7:0];
    assign resHighView = leftJustify ? result[9:2] : {6'h00, result[9:8]};

    // ***********************************************************
    // Control registers
    // ***********************************************************
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            enable   <= 1'b0;
            autoTrig <= 1'b0;
            prescale <= adcs_pkg::PRESCALE_RST;
        end else if (wrAccess && paddr == adcs_pkg::CTRL_A_OFS) begin
            enable   <= pwdata[adcs_pkg::CA_ENABLE];
            autoTrig <= pwdata[adcs_pkg::CA_AUTO];
            prescale <= pwdata[2:0];
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            channel     <= adcs_pkg::CHANNEL_RST;
            reference   <= adcs_pkg::REF_RST;
            leftJustify <= 1'b0;
        end else if (wrAccess && paddr == adcs_pkg::INSEL_OFS) begin
            channel     <= pwdata[3:0];
            reference   <= pwdata[adcs_pkg::IS_REF +: 2];
            leftJustify <= pwdata[adcs_pkg::IS_LEFT];
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            trigSelect  <= adcs_pkg::TRIGSEL_RST;
            powerReduce <= adcs_pkg::POWER_RST;
        end else if (wrAccess && paddr == adcs_pkg::CTRL_B_OFS) begin
            trigSelect <= pwdata[2:0];
        end else if (wrAccess && paddr == adcs_pkg::POWER_OFS) begin
            powerReduce <= pwdata[0];
        end
    end

    // Start bit reads one from the write until the conversion ends
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            startReq <= 1'b0;
        end else if (!effEnable) begin
            startReq <= 1'b0;
        end else if (startWrite || autoStart) begin
            startReq <= 1'b1;
        end else if (done && !freeRun) begin
            startReq <= 1'b0;
        end
    end

    assign ctrlAView = {enable, startReq, autoTrig, flag, 1'b0, prescale};

    // Read data registered in the setup phase
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            unique case (paddr)
                adcs_pkg::CTRL_A_OFS:   prdata <= {24'h00_0000, ctrlAView};
                adcs_pkg::INSEL_OFS:    prdata <= {24'h00_0000, reference,
                                         leftJustify, 1'b0, channel};
                adcs_pkg::CTRL_B_OFS:   prdata <= {29'h0000_0000, trigSelect};
                adcs_pkg::RES_LOW_OFS:  prdata <= {24'h00_0000, resLowView};
                adcs_pkg::RES_HIGH_OFS: prdata <= {24'h00_0000, resHighView};
                adcs_pkg::POWER_OFS:    prdata <= {31'h0000_0000, powerReduce};
                default:                prdata <= 32'h0000_0000;
            endcase
        end
    end

    always_comb begin
        unique case (paddr)
            adcs_pkg::CTRL_A_OFS, adcs_pkg::INSEL_OFS, adcs_pkg::CTRL_B_OFS,
            adcs_pkg::RES_LOW_OFS, adcs_pkg::RES_HIGH_OFS,
            adcs_pkg::POWER_OFS: pslverr = 1'b0;
            default:             pslverr = psel && penable;
        endcase
    end

    // ***********************************************************
    // Assertions
    // ***********************************************************
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    a_flag_after_done: assert property (done |=> flag)
        else $error("flag not set after completion");
    a_lock_holds_result: assert property (
        locked && done |=> $stable(result))
        else $error("locked result was overwritten");
    a_busy_reads_start: assert property (analog.convert |-> startReq)
        else $error("start bit low during conversion");
    a_disable_goes_idle: assert property (
        !effEnable |=> state == adcs_pkg::IDLE)
        else $error("converter active while disabled");
    a_done_length: assert property (
        done |-> (doneHalf == adcs_pkg::FIRST_DONE)
                 == (shHalf == adcs_pkg::FIRST_SH)
                 && halfCount == doneHalf - 6'h01)
        else $error("conversion length wrong");
    a_hold_moment: assert property (
        $rose(analog.sampleHold) |-> halfCount == shHalf
                                     && $past(halfCount) != shHalf)
        else $error("sample-and-hold at wrong time");
    a_free_restart: assert property (
        done && freeRun |=> analog.convert && halfCount == 6'h00 && startReq)
        else $error("free running did not restart");
    a_single_clears: assert property (
        done && !freeRun |=> !analog.convert
                             && (!startReq || $past(startWrite)))
        else $error("single conversion did not end");
    a_buffer_frozen: assert property (
        analog.convert && !unfrozen |=> $stable(bufChannel))
        else $error("channel changed mid conversion");
    a_edge_ignored: assert property (
        analog.convert && trigEdge |=> !syncPipe[0])
        else $error("trigger edge accepted while busy");
    a_start_on_edge: assert property (
        state == adcs_pkg::WAIT_EDGE && riseTick && !autoStart
        |=> analog.convert && halfCount == 6'h00)
        else $error("start not on converter edge");
    // Edge seen, two more pipe stages, then the start edge
    a_auto_sync: assert property (
        syncPipe[0] && effEnable && autoTrig && !freeRun
        ##1 effEnable && autoTrig && !freeRun
        ##1 effEnable && !analog.convert |=> analog.convert)
        else $error("auto trigger sync delay wrong");

    c_free_run:   cover property (done && freeRun ##1 analog.convert);
    c_lock_drop:  cover property (done && locked);
    c_auto_start: cover property (autoStart);
    c_first_conv: cover property (done && doneHalf == adcs_pkg::FIRST_DONE);
endmodule

// [testbench/adcs_analog_model.sv]
// Analog side model: comparator code chosen by the buffered channel
`timescale 1ns/1ps
module adcs_analog_model (
    // Clock and converter controls
    input  wire logic                   clock,
    input  wire adcs_pkg::adcs_analog_t analog,
    // Comparator result
    output logic [9:0]                  convCode
);
    logic [9:0] junk = 10'h155;
    logic [9:0] held = 10'h000;
    // Idle code flips each cycle so a stale sample shows
    always_ff @(posedge clock) begin
        junk <= ~junk;
    end
    // Input frozen at sample-and-hold; later selection changes miss it
    always_ff @(posedge clock) begin
        if (analog.sampleHold && analog.channel[3]) begin
            held <= analog.channel[0] ? 10'h000 : 10'h200;
        end else if (analog.sampleHold) begin
            held <= {analog.channel[2:0], 7'h55};
        end
    end
    always_comb begin
        convCode = analog.convert ? held : junk;
    end
endmodule

// [testbench/adc_conversion_sequencer_bench.sv]
// Bench for the conversion sequencer
`timescale 1ns/1ps
module adc_conversion_sequencer_bench;
    typedef struct {logic w; logic [7:0] a; logic [31:0] d, e;} adcs_row_t;
    localparam logic [7:0] CA = adcs_pkg::CTRL_A_OFS;
    localparam logic [7:0] IS = adcs_pkg::INSEL_OFS;
    localparam logic [7:0] CB = adcs_pkg::CTRL_B_OFS;
    localparam logic [7:0] RL = adcs_pkg::RES_LOW_OFS;
    localparam logic [7:0] RH = adcs_pkg::RES_HIGH_OFS;
    localparam logic [7:0] PW = adcs_pkg::POWER_OFS;
    // Divide by two: the model needs no full resolution, runs stay short
    localparam logic [31:0] EN = 32'h0000_0081;
    logic        clock = 1'b0;
    logic        nrst = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        pready, pslverr, lastErr;
    logic [31:0] prdata, rd;
    logic [7:0]  trigLines = 8'h00;
    logic [9:0]  convCode;
    adcs_pkg::adcs_analog_t analog;
    int fail_count = 0;
    int comparisons = 0;
    int cnt = 0, lastLen = 0, nConv = 0, firstLen, normLen, n;
    adcs_row_t rows [6] = '{'{0, CA, 0, 0}, '{0, IS, 0, 0}, '{0, CB, 0, 0},
        '{0, PW, 0, 0}, '{1, IS, 32'h0000_00E5, 32'h0000_00E5},
        '{1, CB, 32'h0000_0007, 32'h0000_0007}};
    adcs_sequencer #(.TRIG_LINES(8)) i_adcs_sequencer (.clock(clock),
        .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .trigLines(trigLines), .convCode(convCode),
        .analog(analog));
    adcs_analog_model i_adcs_analog_model (.clock(clock), .analog(analog),
        .convCode(convCode));
    initial begin
        forever #12.5 clock = ~clock;
    end
    // Length of each finished conversion in system clocks
    always @(posedge clock) begin
        if (analog.convert === 1'b1) begin
            cnt <= cnt + 1;
        end else if (cnt != 0) begin
            lastLen <= cnt;
            nConv <= nConv + 1;
            cnt <= 0;
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clock);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        lastErr = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // Bounded wait for the next finished conversion
    task automatic waitDone();
        int k;
        k = nConv;
        for (int i = 0; i < 200 && nConv == k; i++) @(posedge clock);
        chk(nConv, k + 1);
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #(25 * 20000);
        fail_count++;
        end_of_test();
    end
    initial begin
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        foreach (rows[k]) begin
            if (rows[k].w) apb(1'b1, rows[k].a, rows[k].d);
            apb(1'b0, rows[k].a, 0);
            chk(rd & 32'h0000_00FF, rows[k].e);
        end
        apb(1'b0, 8'h18, 0);
        chk(lastErr, 1);
        apb(1'b1, IS, 32'h0000_0003);
        // Enable first: a start is only taken once enabled
        apb(1'b1, CA, EN);
        apb(1'b1, CA, EN | 32'h0000_0040);
        repeat (8) @(posedge clock);
        apb(1'b1, IS, 32'h0000_0006);
        waitDone();
        firstLen = lastLen;
        apb(1'b0, CA, 0);
        chk(rd & 32'h0000_0050, 32'h0000_0010);
        apb(1'b0, RL, 0);
        chk(rd, 32'h0000_00D5);
        apb(1'b0, RH, 0);
        chk(rd, 32'h0000_0001);
        // Low byte read locks; this conversion's result is lost
        apb(1'b1, CA, EN | 32'h0000_0010);
        apb(1'b0, RL, 0);
        apb(1'b1, CA, EN | 32'h0000_0040);
        waitDone();
        normLen = lastLen;
        chk(firstLen - normLen, 24);
        apb(1'b0, CA, 0);
        chk(rd & 32'h0000_0010, 32'h0000_0010);
        apb(1'b0, RH, 0);
        chk(rd, 32'h0000_0001);
        apb(1'b0, RL, 0);
        chk(rd, 32'h0000_00D5);
        apb(1'b0, RH, 0);
        apb(1'b1, IS, 32'h0000_0026);
        apb(1'b1, CA, EN | 32'h0000_0040);
        waitDone();
        apb(1'b0, RL, 0);
        chk(rd, 32'h0000_0040);
        apb(1'b0, RH, 0);
        chk(rd, 32'h0000_00D5);
        // Trigger line 2; second edge mid-conversion, then held high
        apb(1'b1, CB, 32'h0000_0002);
        apb(1'b1, CA, EN | 32'h0000_0020);
        n = nConv;
        trigLines <= 8'h04;
        repeat (12) @(posedge clock);
        trigLines <= 8'h00;
        @(posedge clock);
        trigLines <= 8'h04;
        waitDone();
        chk(lastLen - normLen, 1);
        repeat (80) @(posedge clock);
        chk(nConv, n + 1);
        apb(1'b1, CB, 32'h0000_0000);
        apb(1'b1, CA, EN | 32'h0000_0060);
        repeat (120) @(posedge clock);
        apb(1'b0, CA, 0);
        chk(rd & 32'h0000_0040, 32'h0000_0040);
        apb(1'b1, CA, 0);
        apb(1'b0, CA, 0);
        chk(rd & 32'h0000_0040, 0);
        apb(1'b1, PW, 32'h0000_0001);
        apb(1'b1, CA, EN);
        @(posedge clock);
        chk(analog.enable, 0);
        chk(analog.channel, 4'hF);
        apb(1'b1, PW, 32'h0000_0000);
        @(posedge clock);
        chk(analog.enable, 1);
        chk(analog.channel, 4'h6);
        end_of_test();
    end
endmodule
